//--- inc/dbg_cnt_pkg.sv
package dbg_cnt_pkg;

    // Counter geometry and fixed values
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] ONE_CNT = 16'h0001;

    // Width of a command code from the serial deframer
    localparam int OP_W = 4;

    // Field positions of the status word returned by the status read
    localparam int ST_MODE_LSB = 0;
    localparam int ST_STATE_LSB = 2;
    localparam int ST_HALT_BIT = 4;
    localparam int ST_BRK_BIT = 5;
    localparam int ST_RP_BIT = 6;

    // Counter uses, picked by the mode command
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_CYCLE = 2'b01,
        MODE_DOWN = 2'b10,
        MODE_MATCH = 2'b11
    } cnt_mode_t;

    localparam cnt_mode_t MODE_RESET = MODE_OFF;

    // Command codes delivered by the serial deframer
    typedef enum logic [3:0] {
        OP_RD_STATUS = 4'h0,
        OP_RD_CNT = 4'h1,
        OP_WR_CNT = 4'h2,
        OP_SET_MODE = 4'h3,
        OP_RD_REG = 4'h4,
        OP_WR_REG = 4'h5,
        OP_RD_MEM = 4'h6,
        OP_WR_MEM = 4'h7,
        OP_CRC = 4'h8
    } dbg_op_t;

    // Command sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_CRC = 2'b10
    } seq_state_t;

endpackage

//--- inc/cnt_if.sv
`timescale 1ns/10ps
interface cnt_if;
    import dbg_cnt_pkg::*;

    logic load;
    logic [CNT_W-1:0] load_val;
    logic up;
    logic down;
    logic [CNT_W-1:0] count;

    modport ctrl (
        output load,
        output load_val,
        output up,
        output down,
        input count
    );

    modport core (
        input load,
        input load_val,
        input up,
        input down,
        output count
    );
endinterface

//--- logic/dbg_counter_core.sv
`timescale 1ns/10ps
module dbg_counter_core
    import dbg_cnt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    cnt_if.core cnt
);

    // One shared counter; a load beats any count step
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt.count <= CNT_RESET;
        end else if (cnt.load) begin
            cnt.count <= cnt.load_val;
        end else if (cnt.up && cnt.count != CNT_MAX) begin
            cnt.count <= cnt.count + ONE_CNT; // Saturates at the top
        end else if (cnt.down && cnt.count != CNT_ZERO) begin
            cnt.count <= cnt.count - ONE_CNT; // Never wraps below zero
        end
    end

endmodule

//--- logic/dbg_counter_gate.sv
`timescale 1ns/10ps
module dbg_counter_gate
    import dbg_cnt_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic DEBUG_HALT_I,
    input wire logic [CNT_W-1:0] PC_I,
    input wire logic READ_PROTECT_I,
    input wire logic CMD_VALID_I,
    input wire logic CMD_SRC_SERIAL_I,
    input wire logic [OP_W-1:0] CMD_CODE_I,
    input wire logic [CNT_W-1:0] CMD_DATA_I,
    input wire logic BYTE_STROBE_I,
    input wire logic CRC_VALID_I,
    input wire logic [CNT_W-1:0] CRC_RESIDUAL_I,
    output logic BREAK_REQ_O,
    output logic CMD_ACCEPT_O,
    output logic CMD_REJECT_O,
    output logic BYTES_DONE_O,
    output logic [CNT_W-1:0] RD_DATA_O,
    output logic [CNT_W-1:0] COUNT_O
);

    logic rst_meta;
    logic rst_n;
    logic halt_q;
    cnt_mode_t mode;
    seq_state_t state;
    logic take;
    logic is_xfer;
    logic exit_pulse;
    logic running;
    logic next_brk;
    dbg_op_t op;

    cnt_if cnt ();

    dbg_counter_core u_core (
        .clk_i(CORE_CLK_I),
        .rst_n_i(rst_n),
        .cnt(cnt)
    );

    // Commands allowed while the core runs normally
    function automatic logic ok_running(input dbg_op_t o);
        ok_running = (o == OP_RD_STATUS) || (o == OP_RD_CNT);
    endfunction

    // Commands that could leak program memory contents
    function automatic logic rp_blocked(input dbg_op_t o);
        rp_blocked = (o == OP_RD_MEM) || (o == OP_RD_REG) || (o == OP_CRC);
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Command gate decisions
    assign op = dbg_op_t'(CMD_CODE_I);
    assign running = !DEBUG_HALT_I;
    assign take = CMD_VALID_I && CMD_SRC_SERIAL_I
        && (DEBUG_HALT_I || ok_running(op))
        && !(READ_PROTECT_I && rp_blocked(op));
    assign is_xfer = (op == OP_RD_REG) || (op == OP_WR_REG)
        || (op == OP_RD_MEM) || (op == OP_WR_MEM);
    assign exit_pulse = halt_q && !DEBUG_HALT_I;

    // Halt history, for spotting the exit from debug halt
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= DEBUG_HALT_I;
        end
    end

    // Counter use selection; only the mode command changes it
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_RESET;
        end else if (take && op == OP_SET_MODE) begin
            mode <= cnt_mode_t'(CMD_DATA_I[1:0]);
        end
    end

    // Sequencer for byte transfers and CRC runs
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else if (take && is_xfer) begin
            state <= ST_XFER;
        end else if (take && op == OP_CRC) begin
            state <= ST_CRC;
        end else begin
            case (state)
                ST_XFER: begin
                    if (cnt.count == CNT_ZERO) begin
                        state <= ST_IDLE;
                    end
                end
                ST_CRC: begin
                    if (CRC_VALID_I) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Counter steering; command traffic overwrites any break setup
    always_comb begin
        cnt.load = 1'b0;
        cnt.load_val = CMD_DATA_I;
        cnt.up = 1'b0;
        cnt.down = 1'b0;
        if (take && (op == OP_WR_CNT || is_xfer)) begin
            cnt.load = 1'b1; // Byte count or host value
        end else if (state == ST_CRC && CRC_VALID_I) begin
            cnt.load = 1'b1;
            cnt.load_val = CRC_RESIDUAL_I;
        end else if (state == ST_XFER) begin
            cnt.down = BYTE_STROBE_I;
        end else if (state == ST_IDLE && running) begin
            case (mode)
                MODE_CYCLE: begin
                    if (exit_pulse) begin
                        cnt.load = 1'b1;
                        cnt.load_val = CNT_ZERO;
                    end else begin
                        cnt.up = 1'b1;
                    end
                end
                MODE_DOWN: begin
                    cnt.down = 1'b1;
                end
                default: begin
                    cnt.up = 1'b0;
                end
            endcase
        end
    end

    // Break request holds until the core is back in debug halt
    always_comb begin
        next_brk = BREAK_REQ_O;
        if (DEBUG_HALT_I) begin
            next_brk = 1'b0;
        end else if (state == ST_IDLE) begin
            if (mode == MODE_DOWN && cnt.count == CNT_ZERO) begin
                next_brk = 1'b1;
            end else if (mode == MODE_MATCH && cnt.count == PC_I) begin
                next_brk = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            BREAK_REQ_O <= 1'b0;
        end else begin
            BREAK_REQ_O <= next_brk;
        end
    end

    // Per-command answer pulses; a dropped command never reaches the counter
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            CMD_ACCEPT_O <= 1'b0;
            CMD_REJECT_O <= 1'b0;
        end else begin
            CMD_ACCEPT_O <= take;
            CMD_REJECT_O <= CMD_VALID_I && !take;
        end
    end

    // End of a byte transfer
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            BYTES_DONE_O <= 1'b0;
        end else begin
            BYTES_DONE_O <= state == ST_XFER && cnt.count == CNT_ZERO && !take;
        end
    end

    // Read-back data and the counter mirror
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            RD_DATA_O <= CNT_ZERO;
            COUNT_O <= CNT_RESET;
        end else begin
            COUNT_O <= cnt.count;
            if (take && op == OP_RD_CNT) begin
                RD_DATA_O <= cnt.count;
            end else if (take && op == OP_RD_STATUS) begin
                RD_DATA_O <= CNT_ZERO;
                RD_DATA_O[ST_MODE_LSB +: 2] <= mode;
                RD_DATA_O[ST_STATE_LSB +: 2] <= state;
                RD_DATA_O[ST_HALT_BIT] <= DEBUG_HALT_I;
                RD_DATA_O[ST_BRK_BIT] <= BREAK_REQ_O;
                RD_DATA_O[ST_RP_BIT] <= READ_PROTECT_I;
            end
        end
    end

    AST_CYC_INC: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (mode == MODE_CYCLE && state == ST_IDLE && running && !exit_pulse && !take
            && cnt.count != CNT_MAX) |=> cnt.count == $past(cnt.count) + ONE_CNT)
        else $error("cycle count did not step by one");

    AST_CYC_SAT: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (mode == MODE_CYCLE && state == ST_IDLE && cnt.count == CNT_MAX && !cnt.load)
            |=> cnt.count == CNT_MAX)
        else $error("cycle count left saturation");

    AST_CYC_CLR: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (mode == MODE_CYCLE && state == ST_IDLE && exit_pulse && !take)
            |=> cnt.count == CNT_ZERO ##1 COUNT_O == CNT_ZERO)
        else $error("counter not cleared on halt exit");

    AST_DOWN_BRK: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (mode == MODE_DOWN && state == ST_IDLE && running && cnt.count == CNT_ZERO)
            |=> BREAK_REQ_O)
        else $error("countdown reached zero without break");

    AST_MATCH_BRK: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (mode == MODE_MATCH && state == ST_IDLE && running && cnt.count == PC_I)
            |=> BREAK_REQ_O)
        else $error("match did not raise break");

    AST_ONLY_SEL: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        $rose(BREAK_REQ_O) |-> $past(mode) == MODE_DOWN || $past(mode) == MODE_MATCH)
        else $error("break raised by unselected use");

    AST_XFER_LD: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (take && is_xfer) |=> cnt.count == $past(CMD_DATA_I) && state == ST_XFER)
        else $error("transfer byte count not loaded");

    AST_CRC_LD: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (state == ST_CRC && CRC_VALID_I && !take) |=> cnt.count == $past(CRC_RESIDUAL_I))
        else $error("crc residual not held");

    AST_SRC: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CMD_VALID_I && !CMD_SRC_SERIAL_I) |=> CMD_REJECT_O && !CMD_ACCEPT_O)
        else $error("command from wrong source accepted");

    AST_RUN_SUB: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CMD_VALID_I && running && !ok_running(op)) |=> CMD_REJECT_O)
        else $error("full command accepted while running");

    AST_HALT_ALL: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CMD_VALID_I && CMD_SRC_SERIAL_I && DEBUG_HALT_I && !READ_PROTECT_I) |=> CMD_ACCEPT_O)
        else $error("halted command refused without protection");

    AST_RP: assert property (@(posedge CORE_CLK_I) disable iff (!rst_n)
        (CMD_VALID_I && READ_PROTECT_I && rp_blocked(op)) |=> CMD_REJECT_O && !CMD_ACCEPT_O)
        else $error("protected command accepted");

endmodule

//--- verification/dbg_host_model.sv
`timescale 1ns/10ps
// Host at the far end of the serial debug pin
module dbg_host_model
    import dbg_cnt_pkg::*;
(
    input wire logic clk_i,
    output logic valid_o,
    output logic src_o,
    output logic [OP_W-1:0] code_o,
    output logic [CNT_W-1:0] data_o
);
    initial begin
        valid_o = 1'b0;
        src_o = 1'b0;
        code_o = 4'hF;
        data_o = 16'h0000;
    end

    // One command pulse; fields flip when released so stale values never match
    task automatic send(input logic [OP_W-1:0] c, input logic [CNT_W-1:0] d, input logic s);
        @(posedge clk_i);
        valid_o <= 1'b1;
        src_o <= s;
        code_o <= c;
        data_o <= d;
        @(posedge clk_i);
        valid_o <= 1'b0;
        src_o <= 1'b0;
        code_o <= ~c;
        data_o <= ~d;
        #1;
    endtask
endmodule

//--- verification/debug_counter_and_command_gate_tb.sv
`timescale 1ns/10ps
module debug_counter_and_command_gate_tb;
    import dbg_cnt_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic halt = 1'b1;
    logic rp = 1'b0;
    logic strobe = 1'b0;
    logic crc_v = 1'b0;
    logic [15:0] pc = 16'h0000;
    logic [15:0] crc_res = 16'h0000;
    wire cmd_v;
    wire cmd_s;
    wire [3:0] cmd_c;
    wire [15:0] cmd_d;
    wire break_request;
    wire acc;
    wire rej;
    wire done;
    wire [15:0] rd;
    wire [15:0] cnt;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    dbg_host_model host (.clk_i(clk), .valid_o(cmd_v), .src_o(cmd_s), .code_o(cmd_c),
        .data_o(cmd_d));

    dbg_counter_gate DUT (.CORE_CLK_I(clk), .RST_B_I(rst_b), .DEBUG_HALT_I(halt),
        .PC_I(pc), .READ_PROTECT_I(rp), .CMD_VALID_I(cmd_v), .CMD_SRC_SERIAL_I(cmd_s),
        .CMD_CODE_I(cmd_c), .CMD_DATA_I(cmd_d), .BYTE_STROBE_I(strobe),
        .CRC_VALID_I(crc_v), .CRC_RESIDUAL_I(crc_res), .BREAK_REQ_O(break_request),
        .CMD_ACCEPT_O(acc), .CMD_REJECT_O(rej), .BYTES_DONE_O(done), .RD_DATA_O(rd),
        .COUNT_O(cnt));

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cmd(input logic [3:0] c, input logic [15:0] d, input logic s = 1'b1);
        host.send(c, d, s);
    endtask

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard; the long saturation run needs about 66k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            err_total++;
            final_report();
        end
    end

    task automatic set_halt(input logic h);
        @(posedge clk);
        halt <= h;
    endtask

    // Gating by halt, protection and source; refused writes leave the count alone
    task automatic t_gate;
        logic bad;
        for (int i = 0; i < 16; i++) begin
            cmd(4'(i), 16'h0000);
            chk("acc_halt", acc, 1'b1);
        end
        @(posedge clk);
        rp <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bad = (i == 4 || i == 6 || i == 8);
            cmd(4'(i), 16'h0000);
            chk("acc_rp", acc, !bad);
            chk("rej_rp", rej, bad);
            if (i == 0) begin
                chk("status_rp", rd, 16'h0058);
            end
        end
        @(posedge clk);
        rp <= 1'b0;
        cmd(4'h2, 16'hBEEF);
        cmd(4'h2, 16'h1111, 1'b0);
        chk("rej_src", rej, 1'b1);
        set_halt(1'b0);
        for (int i = 0; i < 16; i++) begin
            cmd(4'(i), 16'h7777);
            chk("acc_run", acc, i < 2);
        end
        cmd(4'h1, 16'h0000);
        chk("cnt_kept", rd, 16'hBEEF);
        set_halt(1'b1);
    endtask

    task automatic t_width;
        cmd(4'h2, 16'hFFFF);
        cmd(4'h1, 16'h0000);
        chk("rd_full", rd, 16'hFFFF);
        chk("mirror", cnt, 16'hFFFF);
    endtask

    // Cycle use: first running edge clears, later ones count
    task automatic t_cycle(input int n, input logic [15:0] exp);
        cmd(4'h2, 16'h1234);
        cmd(4'h3, 16'h0001);
        set_halt(1'b0);
        repeat (n) @(posedge clk);
        halt <= 1'b1;
        #1;
        chk("brk_cyc", break_request, 1'b0);
        cmd(4'h1, 16'h0000);
        chk("cyc_cnt", rd, exp);
    endtask

    task automatic t_down;
        cmd(4'h3, 16'h0002);
        cmd(4'h2, 16'h0003);
        set_halt(1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk("brk_early", break_request, 1'b0);
        @(posedge clk);
        #1;
        chk("brk_zero", break_request, 1'b1);
        cmd(4'h0, 16'h0000);
        chk("status_brk", rd, 16'h0022);
        set_halt(1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk("brk_clr", break_request, 1'b0);
    endtask

    // Match use as a temporary stop at one target address
    task automatic t_match;
        cmd(4'h3, 16'h0003);
        cmd(4'h2, 16'h0040);
        @(posedge clk);
        pc <= 16'h0030;
        halt <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("brk_nomatch", break_request, 1'b0);
        @(posedge clk);
        pc <= 16'h0040;
        repeat (2) @(posedge clk);
        #1;
        chk("brk_match", break_request, 1'b1);
        set_halt(1'b1);
        repeat (2) @(posedge clk);
    endtask

    task automatic t_xfer;
        int k;
        cmd(4'h2, 16'hAAAA);
        cmd(4'h7, 16'h0002);
        @(posedge clk);
        strobe <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        strobe <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 10) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("bytes_done", done, 1'b1);
        cmd(4'h1, 16'h0000);
        chk("xfer_cnt", rd, 16'h0000);
    endtask

    task automatic t_crc;
        cmd(4'h8, 16'h0000);
        @(posedge clk);
        crc_v <= 1'b1;
        crc_res <= 16'h5A5A;
        @(posedge clk);
        crc_v <= 1'b0;
        crc_res <= 16'hA5A5;
        cmd(4'h1, 16'h0000);
        chk("crc_cnt", rd, 16'h5A5A);
    endtask

    // Mid-run reset: counter, mode and sequencer must all return to rest
    task automatic t_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("cnt_rst2", cnt, 16'h0000);
        cmd(4'h0, 16'h0000);
        chk("status_rst", rd, 16'h0010);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("cnt_rst", cnt, 16'h0000);
        chk("brk_rst", break_request, 1'b0);
        t_gate();
        t_width();
        t_cycle(10, 16'h0009);
        t_cycle(65540, 16'hFFFF);
        t_down();
        t_match();
        t_xfer();
        t_crc();
        t_reset();
        final_report();
    end
endmodule
